// *** core/sxr_defines.svh ***
// What this block does
// - Per-character select code is used only in variable select mode.
// - Without decoding, only the lowest zero bit of the code drives low.
// - With decoding, the four select lines carry the code directly.
// - In variable select mode, final-character flag releases the select after shifting, despite hold-select.
// - Receive-full sets on shifter-to-holding move, clears on holding read.
// - Transmit-empty clears on holding write, sets when moved into shifter.
// - Transmit-empty is zero at reset and while disabled; enabling sets it.
// - Mode fault latches on detection, clears on status read.
// - Overrun sets on a second receive load without read; status read clears.
// - Receive DMA end sets when counter reaches zero, clears on counter write.
// - Transmit DMA end sets when counter reaches zero, clears on counter write.
// - Receive all-done reads one exactly when both receive counters are zero.
// - Transmit all-done reads one exactly when both transmit counters are zero.
// - Slave-select rising edge latches a flag; status read clears it.
// - All-empty clears on holding write, sets when idle after transfer delay.
// - Status shows the enable state as a read-only bit.
// - Writing one to enable-set register enables that source; zero ignored.
// - Writing one to enable-clear register disables that source; zero ignored.
// - The four DMA counter values come from the external DMA unit.
// - A readable mask holds enabled sources at the status bit positions.
// - Select mode one is variable selection, zero is fixed selection.
//
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte offsets on an 8-bit register address
// Notes:   definitions only
`ifndef SXR_DEFINES_SVH
`define SXR_DEFINES_SVH

`define SXR_OFS_CTRL      8'h00
`define SXR_OFS_MODE      8'h04
`define SXR_OFS_RXHOLD    8'h08
`define SXR_OFS_TXHOLD    8'h0c
`define SXR_OFS_STATUS    8'h10
`define SXR_OFS_IRQ_SET   8'h14
`define SXR_OFS_IRQ_CLR   8'h18
`define SXR_OFS_IRQ_MASK  8'h1c
`define SXR_OFS_XFER_CFG  8'h30

`define SXR_CTRL_EN       0
`define SXR_CTRL_DIS      1
`define SXR_MODE_VAR      1
`define SXR_MODE_DEC      2
`define SXR_MODE_FDIS     4
`define SXR_MODE_CODE     16
`define SXR_TD_CODE       16
`define SXR_TD_FINAL      24
`define SXR_CFG_HOLD      3
`define SXR_CFG_DLY       24
`define SXR_SR_ENABLED    16

`define SXR_SRC_MASK      10'h3ff
`define SXR_CS_NONE       4'hf
`define SXR_DLY_UNIT      5
`define SXR_BAUD_HALF     4'h4
`define SXR_CHAR_LAST     3'h7

`endif

// *** core/sxr_pkg.sv ***
// Purpose: shared types of the serial unit register block
// Assumes: nothing beyond the defines header
// Notes:   types only
package sxr_pkg;

  typedef enum logic [1:0] {
    SXR_TX_IDLE  = 2'b00,
    SXR_TX_SHIFT = 2'b01,
    SXR_TX_GAP   = 2'b10
  } sxr_tx_t;

  typedef struct packed {
    logic [15:0] rx_cnt;
    logic [15:0] rx_next_cnt;
    logic [15:0] tx_cnt;
    logic [15:0] tx_next_cnt;
    logic        rx_cnt_wr;
    logic        tx_cnt_wr;
  } sxr_dma_t;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic       sck;
    logic       mosi;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
  } sxr_shift_t;

endpackage

// *** core/sxr_sync.sv ***
// Purpose: two-flop synchroniser for the slave-select and data inputs
// Assumes: inputs are asynchronous to clk
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module sxr_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Pins in, synchronised out
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);
  logic [1:0] meta_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule

// *** core/sxr_shift.sv ***
// Purpose: eight-bit serial shifter, clock idle low, sample on rise
// Assumes: tick is a one-cycle enable from the baud divider
// Notes:   done pulses for one cycle when the last bit has finished
`timescale 1ns/100ps
`include "sxr_defines.svh"
module sxr_shift
  import sxr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] tx_char,
  input  wire logic       miso,
  // Results and pins
  output sxr_shift_t      st
);
  sxr_shift_t st_d;

  always_comb begin
    st_d      = st;
    st_d.done = 1'b0;
    if (start && !st.busy) begin
      st_d.busy = 1'b1;
      st_d.sck  = 1'b0;
      st_d.cnt  = 3'h0;
      st_d.sh   = tx_char;
      st_d.mosi = tx_char[7];
    end else if (tick && st.busy) begin
      if (!st.sck) begin
        st_d.sck = 1'b1;
        st_d.rx  = {st.rx[6:0], miso};
      end else begin
        st_d.sck = 1'b0;
        if (st.cnt == `SXR_CHAR_LAST) begin
          st_d.busy = 1'b0;
          st_d.done = 1'b1;
        end else begin
          st_d.cnt  = st.cnt + 3'h1;
          st_d.sh   = {st.sh[6:0], 1'b0};
          st_d.mosi = st.sh[6];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st <= '0;
    else       st <= st_d;
  end
endmodule

// *** core/sxr_regs.sv ***
// Purpose: transmit holding, status flags and interrupt enables of the
//          serial unit, with a minimal master shifter behind them
// Assumes: single clock, register port with read data one cycle later
// Notes:   DMA counters live outside and arrive on dma_in
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "sxr_defines.svh"
module sxr_regs
  import sxr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // DMA unit counters
  input  wire sxr_dma_t    dma_in,
  // Serial pins
  input  wire logic        slave_select_input,
  input  wire logic        miso,
  output logic             sck,
  output logic             mosi,
  output logic      [3:0]  chip_select_lines,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic        en;
    logic        mode_var;
    logic        dec_en;
    logic        fdis;
    logic [3:0]  fix_code;
    logic        hold_sel;
    logic [7:0]  dly;
    logic [9:0]  imr;
    logic        rx_full;
    logic        tx_holding_empty_flag;
    logic        mode_fault_flag;
    logic        ovr;
    logic        rx_dma_end_flag;
    logic        tx_dma_end_flag;
    logic        slave_select_rise_flag;
    logic        all_tx_empty_flag;
    logic [15:0] th_char;
    logic [3:0]  th_code;
    logic        th_final;
    logic [7:0]  sh_char;
    logic [15:0] rdr;
    logic [3:0]  cs;
    logic        cur_final;
    sxr_tx_t     fsm;
    logic [12:0] dcnt;
    logic        start;
    logic [3:0]  div;
    logic        tick;
    logic        ss_prev;
    logic        rxz_prev;
    logic        txz_prev;
    logic [31:0] rdata;
    logic        irq;
  } sxr_state_t;

  sxr_state_t q, d;
  sxr_shift_t sh;
  logic [1:0] pins_s;
  logic       nss_s;
  logic       wr_ctl, wr_mode, wr_td, wr_set, wr_clr, wr_cfg;
  logic       rd_sr, rd_rdr, load, ss_rise, mode_fault_flag_evt;
  logic       rx_dma_all_done_flag, tx_dma_all_done_flag, rx_zero, tx_zero;
  logic [3:0] cs_pick;
  logic [31:0] sr_vec;

  // Lowest zero bit selects; all ones selects nothing
  function automatic logic [3:0] cs_map(input logic [3:0] code,
                                        input logic       dec);
    if (dec)           cs_map = code;
    else if (!code[0]) cs_map = 4'he;
    else if (!code[1]) cs_map = 4'hd;
    else if (!code[2]) cs_map = 4'hb;
    else if (!code[3]) cs_map = 4'h7;
    else               cs_map = `SXR_CS_NONE;
  endfunction

  sxr_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .pin_in   ({miso, slave_select_input}),
    .pin_sync (pins_s)
  );
  assign nss_s = pins_s[0];

  sxr_shift u_shift (
    .clk     (clk),
    .nrst    (nrst),
    .tick    (q.tick),
    .start   (q.start),
    .tx_char (q.sh_char),
    .miso    (pins_s[1]),
    .st      (sh)
  );

  assign wr_ctl  = wr && (addr == `SXR_OFS_CTRL);
  assign wr_mode = wr && (addr == `SXR_OFS_MODE);
  assign wr_td   = wr && (addr == `SXR_OFS_TXHOLD);
  assign wr_set  = wr && (addr == `SXR_OFS_IRQ_SET);
  assign wr_clr  = wr && (addr == `SXR_OFS_IRQ_CLR);
  assign wr_cfg  = wr && (addr == `SXR_OFS_XFER_CFG);
  assign rd_sr   = rd && (addr == `SXR_OFS_STATUS);
  assign rd_rdr  = rd && (addr == `SXR_OFS_RXHOLD);

  // Counters come from the DMA unit, nothing is stored here
  assign rx_zero = (dma_in.rx_cnt == 16'h0);
  assign tx_zero = (dma_in.tx_cnt == 16'h0);
  assign rx_dma_all_done_flag  = rx_zero && (dma_in.rx_next_cnt == 16'h0);
  assign tx_dma_all_done_flag  = tx_zero && (dma_in.tx_next_cnt == 16'h0);

  assign ss_rise  = nss_s && !q.ss_prev;
  assign mode_fault_flag_evt = q.en && !q.fdis && !nss_s;
  assign load     = (q.fsm == SXR_TX_IDLE) && q.en && !q.tx_holding_empty_flag && !sh.busy;
  // Fixed mode ignores the code written with the character
  assign cs_pick  = cs_map(q.mode_var ? q.th_code : q.fix_code,
                           q.dec_en);

  // Reserved positions stay zero
  assign sr_vec = {15'h0, q.en, 6'h0, q.all_tx_empty_flag, q.slave_select_rise_flag, tx_dma_all_done_flag, rx_dma_all_done_flag,
                   q.tx_dma_end_flag, q.rx_dma_end_flag, q.ovr, q.mode_fault_flag, q.tx_holding_empty_flag,
                   q.rx_full};

  always_comb begin
    d       = q;
    d.start = 1'b0;
    d.rdata = 32'h0;

    // Baud divider
    d.tick = 1'b0;
    if (q.div == `SXR_BAUD_HALF - 4'h1) begin
      d.div  = 4'h0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 4'h1;
    end

    if (wr_ctl) begin
      if (wdata[`SXR_CTRL_DIS]) begin
        d.en = 1'b0;
      end else if (wdata[`SXR_CTRL_EN]) begin
        d.en   = 1'b1;
        d.tx_holding_empty_flag = 1'b1;
        if (q.fsm == SXR_TX_IDLE && !sh.busy) d.all_tx_empty_flag = 1'b1;
      end
    end
    if (wr_mode) begin
      d.mode_var = wdata[`SXR_MODE_VAR];
      d.dec_en   = wdata[`SXR_MODE_DEC];
      d.fdis     = wdata[`SXR_MODE_FDIS];
      d.fix_code = wdata[`SXR_MODE_CODE +: 4];
    end
    if (wr_cfg) begin
      d.hold_sel = wdata[`SXR_CFG_HOLD];
      d.dly      = wdata[`SXR_CFG_DLY +: 8];
    end
    if (wr_set) d.imr = q.imr | (wdata[9:0] & `SXR_SRC_MASK);
    if (wr_clr) d.imr = q.imr & ~(wdata[9:0] & `SXR_SRC_MASK);

    // Read-to-clear first, so a same-cycle event wins
    if (rd_sr) begin
      d.rdata = sr_vec;
      d.mode_fault_flag  = 1'b0;
      d.ovr   = 1'b0;
      d.slave_select_rise_flag  = 1'b0;
    end
    if (rd_rdr) begin
      d.rdata   = {16'h0, q.rdr};
      d.rx_full = 1'b0;
    end
    if (rd && addr == `SXR_OFS_IRQ_MASK) d.rdata = {22'h0, q.imr};

    if (mode_fault_flag_evt) d.mode_fault_flag = 1'b1;
    d.ss_prev = nss_s;
    if (ss_rise) d.slave_select_rise_flag = 1'b1;

    d.rxz_prev = rx_zero;
    d.txz_prev = tx_zero;
    if (dma_in.rx_cnt_wr) d.rx_dma_end_flag = 1'b0;
    if (dma_in.tx_cnt_wr) d.tx_dma_end_flag = 1'b0;
    if (rx_zero && !q.rxz_prev) d.rx_dma_end_flag = 1'b1;
    if (tx_zero && !q.txz_prev) d.tx_dma_end_flag = 1'b1;

    if (sh.done) begin
      d.rdr     = {8'h0, sh.rx};
      d.rx_full = 1'b1;
      if (q.rx_full) d.ovr = 1'b1;
    end

    unique case (q.fsm)
      SXR_TX_IDLE: begin
        if (load) begin
          d.sh_char   = q.th_char[7:0];
          d.start     = 1'b1;
          d.tx_holding_empty_flag      = 1'b1;
          d.cs        = cs_pick;
          d.cur_final = q.mode_var && q.th_final;
          d.fsm       = SXR_TX_SHIFT;
        end
      end
      SXR_TX_SHIFT: begin
        if (sh.done) begin
          d.dcnt = {q.dly, `SXR_DLY_UNIT'(0)};
          d.fsm  = SXR_TX_GAP;
        end
      end
      SXR_TX_GAP: begin
        if (q.dcnt != 13'h0) begin
          d.dcnt = q.dcnt - 13'h1;
        end else begin
          // Final character overrides hold-select
          if (q.cur_final || (q.tx_holding_empty_flag && !q.hold_sel))
            d.cs = `SXR_CS_NONE;
          if (q.tx_holding_empty_flag) d.all_tx_empty_flag = 1'b1;
          d.fsm = SXR_TX_IDLE;
        end
      end
    endcase

    // A write arriving on the load edge must stay pending
    if (wr_td) begin
      d.th_char  = wdata[15:0];
      d.th_code  = wdata[`SXR_TD_CODE +: 4];
      d.th_final = wdata[`SXR_TD_FINAL];
      d.tx_holding_empty_flag     = 1'b0;
      d.all_tx_empty_flag  = 1'b0;
    end
    if (!d.en) d.tx_holding_empty_flag = 1'b0;

    d.irq = |(sr_vec[9:0] & q.imr);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q          <= '0;
      q.cs       <= `SXR_CS_NONE;
      q.fix_code <= `SXR_CS_NONE;
      q.ss_prev  <= 1'b1;
      q.rxz_prev <= 1'b1;
      q.txz_prev <= 1'b1;
      q.fsm      <= SXR_TX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rdata             = q.rdata;
  assign irq               = q.irq;
  assign chip_select_lines = q.cs;
  assign sck               = sh.sck;
  assign mosi              = sh.mosi;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_td_clears;
    wr_td |=> !q.tx_holding_empty_flag && !q.all_tx_empty_flag;
  endproperty
  a_td_clears: assert property (p_td_clears)
    else $error("holding write did not clear empty flags");

  property p_dis_tx_holding_empty_flag;
    !q.en |-> !q.tx_holding_empty_flag;
  endproperty
  a_dis_tx_holding_empty_flag: assert property (p_dis_tx_holding_empty_flag)
    else $error("transmit empty set while disabled");

  property p_en_cmd;
    wr_ctl && wdata[`SXR_CTRL_EN] && !wdata[`SXR_CTRL_DIS] |=> q.tx_holding_empty_flag;
  endproperty
  a_en_cmd: assert property (p_en_cmd)
    else $error("enable did not set transmit empty");

  property p_rx_load;
    sh.done ##1 !rd_rdr |=> q.rx_full;
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("receive full lost after load");

  property p_ovr;
    sh.done && q.rx_full |=> q.ovr;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not flagged");

  property p_nss_rise;
    ss_rise |=> q.slave_select_rise_flag;
  endproperty
  a_nss_rise: assert property (p_nss_rise)
    else $error("slave-select rise not latched");

  property p_sr_read;
    rd_sr |=> rdata[6] == $past(rx_dma_all_done_flag) && rdata[7] == $past(tx_dma_all_done_flag)
              && rdata[16] == $past(q.en) && rdata[15:10] == 6'h0;
  endproperty
  a_sr_read: assert property (p_sr_read)
    else $error("status read value wrong");

  property p_imr_set;
    wr_set |=> (q.imr & $past(wdata[9:0])) == $past(wdata[9:0]);
  endproperty
  a_imr_set: assert property (p_imr_set)
    else $error("enable-set did not enable");

  property p_imr_clr;
    wr_clr |=> (q.imr & $past(wdata[9:0])) == 10'h0;
  endproperty
  a_imr_clr: assert property (p_imr_clr)
    else $error("enable-clear did not disable");

  property p_irq;
    ##1 irq == $past(|(sr_vec[9:0] & q.imr));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatch");

  property p_cs_load;
    load |=> chip_select_lines == $past(cs_pick);
  endproperty
  a_cs_load: assert property (p_cs_load)
    else $error("select lines not set on load");

  c_load:    cover property (load);
  c_overrun: cover property (sh.done && q.rx_full);
  c_release: cover property (q.fsm == SXR_TX_GAP && q.cur_final
                             ##1 chip_select_lines == `SXR_CS_NONE);
endmodule

// *** tb/sxr_periph.sv ***
// Purpose: serial peripheral model on the select lines, answers one byte
// Assumes: clock idle low, data taken on rise and changed on fall
// Notes:   while deselected miso toggles every clock, never a stale bit
`timescale 1ns/100ps
module sxr_periph (
  // Clock
  input  wire logic       clk,
  // Serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [3:0] chip_select_lines,
  output logic            miso,
  // Frame results
  input  wire logic [7:0] reply,
  output logic            frame_done,
  output logic [7:0]      got_byte,
  output logic [3:0]      got_cs
);
  logic       sck_q;
  logic       junk;
  logic [2:0] n;
  logic [7:0] tx;

  initial begin
    sck_q = 1'b0;
    junk = 1'b0;
    n = 3'h0;
    tx = 8'h0;
    frame_done = 1'b0;
    got_byte = 8'h0;
    got_cs = 4'hf;
  end

  // Edges of the link clock are found on the system clock
  always @(posedge clk) begin
    sck_q <= sck;
    junk <= ~junk;
    frame_done <= 1'b0;
    if (chip_select_lines == 4'hf) begin
      n <= 3'h0;
      tx <= reply;
    end else if (sck && !sck_q) begin
      got_byte <= {got_byte[6:0], mosi};
      if (n == 3'h0) begin
        got_cs <= chip_select_lines;
      end
      n <= n + 3'h1;
      frame_done <= (n == 3'h7);
    end else if (!sck && sck_q) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  assign miso = (chip_select_lines == 4'hf) ? junk : tx[7];
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the serial unit register block
// Assumes: 20 MHz clock, peripheral model on the select lines
// Notes:   reads and frames are noted in queues, checked when they land
`timescale 1ns/100ps
module tb_top;
  import sxr_pkg::*;
  localparam logic [15:0] CODES = 16'h753a;
  localparam logic [15:0] DECS  = 16'h7dbe;
  logic        clk;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        rd_q;
  logic [31:0] rdata;
  sxr_dma_t    dma;
  logic        ss;
  logic        miso;
  logic        sck;
  logic        mosi;
  logic        irq;
  logic        frame_done;
  logic [3:0]  cs;
  logic [3:0]  got_cs;
  logic [7:0]  got_byte;
  logic [7:0]  reply;
  logic [7:0]  last_rx;
  logic [31:0] m1;
  logic [31:0] m2;
  logic [63:0] rn;
  logic [11:0] fn;
  logic [63:0] rdq[$];
  logic [11:0] frq[$];
  integer      bad_count;
  integer      tests_run;
  integer      seed;
  integer      cyc;
  integer      i;

  sxr_regs uut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .dma_in(dma), .slave_select_input(ss), .miso(miso),
    .sck(sck), .mosi(mosi), .chip_select_lines(cs), .irq(irq)
  );

  sxr_periph peer (
    .clk(clk), .sck(sck), .mosi(mosi), .chip_select_lines(cs),
    .miso(miso), .reply(reply), .frame_done(frame_done),
    .got_byte(got_byte), .got_cs(got_cs)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One idle cycle after each strobe keeps strobes single-assigned
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    rdq.push_back({m, e});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic irq_is(input logic v);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, v});
    @(posedge clk);
  endtask

  task automatic setc(input int k, input logic [15:0] c,
                      input logic [15:0] n, input logic p);
    if (k == 0) begin
      dma.rx_cnt <= c;
      dma.rx_next_cnt <= n;
      dma.rx_cnt_wr <= p;
    end else begin
      dma.tx_cnt <= c;
      dma.tx_next_cnt <= n;
      dma.tx_cnt_wr <= p;
    end
    @(posedge clk);
    dma.rx_cnt_wr <= 1'b0;
    dma.tx_cnt_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic xfer(input logic [3:0] code, input logic fin,
                      input logic [3:0] ecs);
    logic [7:0] ch;
    logic       seen;
    ch = $random(seed);
    last_rx = $random(seed);
    seen = 1'b0;
    reply <= last_rx;
    frq.push_back({ecs, ch});
    wreg(8'h0c, {7'h0, fin, 4'h0, code, 8'h0, ch});
    for (int k = 0; k < 400 && !(seen && cs === 4'hf); k++) begin
      @(posedge clk);
      if (cs !== 4'hf) begin
        seen = 1'b1;
      end
    end
    check({27'h0, seen, cs}, 32'h1f);
  endtask

  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_q) begin
      rn = rdq.pop_front();
      check(rdata & rn[63:32], rn[31:0]);
    end
    if (frame_done) begin
      fn = frq.pop_front();
      check({20'h0, got_cs, got_byte}, {20'h0, fn});
    end
  end

  initial begin
    nrst = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    dma = '{16'h1, 16'h1, 16'h1, 16'h1, 1'b0, 1'b0};
    ss = 1'b1;
    reply = 8'h0;
    last_rx = 8'h0;
    seed = 17;
    cyc = 0;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rreg(8'h10, 32'h0, 32'hffffffff);
    rreg(8'h1c, 32'h0, 32'hffffffff);
    rreg(8'h20, 32'h0, 32'hffffffff);
    m1 = $random(seed);
    m2 = $random(seed);
    wreg(8'h14, m1);
    rreg(8'h1c, m1 & 32'h3ff, 32'hffffffff);
    wreg(8'h18, m2);
    rreg(8'h1c, m1 & ~m2 & 32'h3ff, 32'hffffffff);
    wreg(8'h18, 32'hffffffff);
    wreg(8'h00, 32'h1);
    rreg(8'h10, 32'h10202, 32'hffffffff);
    for (i = 0; i < 2; i++) begin
      setc(i, 16'h0, 16'h3, 1'b0);
      rreg(8'h10, 32'h10 << i, 32'h50 << i);
      setc(i, 16'h0, 16'h0, 1'b0);
      rreg(8'h10, 32'h50 << i, 32'h50 << i);
      setc(i, 16'h0, 16'h0, 1'b1);
      rreg(8'h10, 32'h40 << i, 32'h50 << i);
      setc(i, 16'h5, 16'h2, 1'b0);
      rreg(8'h10, 32'h0, 32'h50 << i);
    end
    // Fixed select: the code sent with the character must not matter
    wreg(8'h30, 32'h0);
    wreg(8'h04, 32'h50000);
    xfer(4'h3, 1'b0, 4'hd);
    rreg(8'h10, 32'h203, 32'h20f);
    wreg(8'h04, 32'h2);
    wreg(8'h30, 32'h8);
    for (i = 0; i < 4; i++) begin
      xfer(CODES[i*4 +: 4], 1'b1, DECS[i*4 +: 4]);
    end
    wreg(8'h04, 32'h6);
    xfer(4'h9, 1'b1, 4'h9);
    rreg(8'h10, 32'h209, 32'h20d);
    rreg(8'h10, 32'h201, 32'h20d);
    rreg(8'h08, {24'h0, last_rx}, 32'hffff);
    rreg(8'h10, 32'h0, 32'h1);
    wreg(8'h14, 32'h100);
    irq_is(1'b0);
    ss <= 1'b0;
    repeat (6) @(posedge clk);
    ss <= 1'b1;
    repeat (6) @(posedge clk);
    irq_is(1'b1);
    rreg(8'h10, 32'h104, 32'h104);
    irq_is(1'b0);
    rreg(8'h10, 32'h0, 32'h104);
    wreg(8'h00, 32'h3);
    rreg(8'h10, 32'h0, 32'h10002);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rreg(8'h1c, 32'h0, 32'hffffffff);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule
